//--- hw/drp_params.svh
/*
  Constants of the reference profile register bank: register indexes,
  field positions, reset values and address map bounds.
  Assumes it is included by bare name from the package only.
*/
// Behaviour
// RULE1 - Two-bit priority in profile bits 2:1
// RULE2 - Bit 0 enables locking to fourth reference
// RULE3 - 17-bit bandwidth from two bytes plus bit
// RULE4 - Software keeps bandwidth below detector rate/20
// RULE5 - Software avoids under 50 Hz with crystal
// RULE6 - Bit 1 picks normal or high margin
// RULE7 - Software picks high margin above 2 kHz
// RULE8 - 18-bit integer divider stored as ratio minus one
// RULE9 - 24-bit numerator, low byte lowest address
// RULE10 - 24-bit modulus, low byte lowest address
// RULE11 - Reset disables reference, clears every field
// RULE12 - Channel one controls mirror at +0x100
// RULE13 - Channel one sync/distribution mirror at +0x100
// RULE14 - Channel one profiles mirror from 0x540
// RULE15 - Channel two controls, analog loop at +0x200
// RULE16 - Reserved bits read zero, ignore writes
`ifndef DRP_PARAMS_SVH
`define DRP_PARAMS_SVH

// Register indexes of channel zero; byte address is index times four
`define DRP_IDX_PRIO_EN 12'h467
`define DRP_IDX_BW_LOW 12'h468
`define DRP_IDX_BW_MID 12'h469
`define DRP_IDX_BW_TOP_FILT 12'h46a
`define DRP_IDX_INT_LOW 12'h46b
`define DRP_IDX_INT_MID 12'h46c
`define DRP_IDX_INT_TOP 12'h46d
`define DRP_IDX_NUM_LOW 12'h46e
`define DRP_IDX_NUM_MID 12'h46f
`define DRP_IDX_NUM_HIGH 12'h470
`define DRP_IDX_MOD_LOW 12'h471
`define DRP_IDX_MOD_MID 12'h472
`define DRP_IDX_MOD_HIGH 12'h473
// Status register holding the last decoded access
`define DRP_IDX_ACCESS_STATUS 12'h7f0

// Pages of the three channels and the per-channel stride
`define DRP_PAGE_CH0 4'h4
`define DRP_PAGE_CH1 4'h5
`define DRP_PAGE_CH2 4'h6
`define DRP_CHANNEL_STRIDE 12'h100

// Bounds of groups inside one channel page
`define DRP_CTRL_FIRST 8'h00
`define DRP_CTRL_LAST 8'h1e
`define DRP_APLL_FIRST 8'h30
`define DRP_APLL_LAST 8'h33
`define DRP_SYNC_FIRST 8'h34
`define DRP_SYNC_LAST 8'h3e
`define DRP_REFS_FIRST 8'h40
`define DRP_FOURTH_REFERENCE_INPUT_FIRST 8'h67
`define DRP_FOURTH_REFERENCE_INPUT_LAST 8'h73

// Field positions
`define DRP_PRIO_LSB 1
`define DRP_EN_BIT 0
`define DRP_FILT_BIT 1
`define DRP_BW_TOP_BIT 0

// Reset values
`define DRP_RST_PRIO 2'h0
`define DRP_RST_EN 1'b0
`define DRP_RST_FILT 1'b0
`define DRP_RST_BW 17'h00000
`define DRP_RST_INT 18'h00000
`define DRP_RST_FRAC 24'h000000

`endif

//--- hw/drp_pkg.sv
/*
  Types of the reference profile register bank.
  Assumes drp_params.svh sits on the include path.
*/
package drp_pkg;
  `include "drp_params.svh"

  // Decoded settings of the fourth reference for one channel
  typedef struct packed {
    logic [1:0] priorityLevel;
    logic enable;
    logic [16:0] loopBandwidth;
    logic highMarginFilter;
    logic [17:0] intDivMinusOne;
    logic [23:0] fracNumerator;
    logic [23:0] fracModulus;
  } drp_profile_type;

  // Register group an address falls in
  typedef enum logic [2:0] {
    GRP_NONE,
    GRP_CONTROLS,
    GRP_ANALOG_CFG,
    GRP_SYNC_DIST,
    GRP_REF_OTHER,
    GRP_REF_FOURTH,
    GRP_STATUS
  } drp_group_type;

  // Result of one address decode
  typedef struct packed {
    logic [1:0] channel;
    drp_group_type group;
    logic [7:0] low;
  } drp_decode_type;

  // Bus handshake states
  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } drp_bus_state_type;
endpackage : drp_pkg

//--- hw/drp_reference_profile_regs.sv
/*
  Register bank of the fourth reference profile for three digital loop
  channels, reached over a classic Wishbone slave with 32-bit data.
  Assumes one clock, an asynchronous active-high reset and a master
  that holds each request until it sees ack.
*/
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps

module drp_reference_profile_regs
  import drp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output drp_profile_type profileChannelZero,
  output drp_profile_type profileChannelOne,
  output drp_profile_type profileChannelTwo
);

  // Classifies a register index into channel and group
  function automatic drp_decode_type decodeIndex(input logic [11:0] idx);
    drp_decode_type d;
    d.low = idx[7:0];
    d.channel = 2'd0;
    d.group = GRP_NONE;
    // Pages of the three channels share one layout
    case (idx[11:8])
      `DRP_PAGE_CH0: begin
        d.channel = 2'd0;
      end
      `DRP_PAGE_CH1: begin
        d.channel = 2'd1; // RULE12
      end
      `DRP_PAGE_CH2: begin
        d.channel = 2'd2; // RULE15
      end
      default: begin
        d.channel = 2'd3;
      end
    endcase
    if (idx == `DRP_IDX_ACCESS_STATUS) begin
      d.group = GRP_STATUS;
      d.channel = 2'd0;
    end else if (d.channel != 2'd3) begin
      // Same low offsets in every page
      if (d.low <= `DRP_CTRL_LAST) begin
        d.group = GRP_CONTROLS; // RULE12
      end else if (d.low >= `DRP_APLL_FIRST && d.low <= `DRP_APLL_LAST) begin
        d.group = GRP_ANALOG_CFG; // RULE15
      end else if (d.low >= `DRP_SYNC_FIRST && d.low <= `DRP_SYNC_LAST) begin
        d.group = GRP_SYNC_DIST; // RULE13
      end else if (d.low >= `DRP_REFS_FIRST && d.low < `DRP_FOURTH_REFERENCE_INPUT_FIRST) begin
        d.group = GRP_REF_OTHER; // RULE14
      end else if (d.low >= `DRP_FOURTH_REFERENCE_INPUT_FIRST && d.low <= `DRP_FOURTH_REFERENCE_INPUT_LAST) begin
        d.group = GRP_REF_FOURTH; // RULE14
      end else begin
        d.group = GRP_NONE;
      end
    end
    return d;
  endfunction : decodeIndex

  // Returns one byte of a profile by its channel-zero low offset
  function automatic logic [7:0] readByte(
    input drp_profile_type p,
    input logic [7:0] low
  );
    logic [7:0] b;
    b = 8'h00;
    // Reserved bits stay zero on every byte
    case ({4'h4, low})
      `DRP_IDX_PRIO_EN: begin
        b = {5'h00, p.priorityLevel, p.enable}; // RULE16
      end
      `DRP_IDX_BW_LOW: begin
        b = p.loopBandwidth[7:0];
      end
      `DRP_IDX_BW_MID: begin
        b = p.loopBandwidth[15:8];
      end
      `DRP_IDX_BW_TOP_FILT: begin
        b = {6'h00, p.highMarginFilter, p.loopBandwidth[16]}; // RULE16
      end
      `DRP_IDX_INT_LOW: begin
        b = p.intDivMinusOne[7:0];
      end
      `DRP_IDX_INT_MID: begin
        b = p.intDivMinusOne[15:8];
      end
      `DRP_IDX_INT_TOP: begin
        b = {6'h00, p.intDivMinusOne[17:16]}; // RULE16
      end
      `DRP_IDX_NUM_LOW: begin
        b = p.fracNumerator[7:0];
      end
      `DRP_IDX_NUM_MID: begin
        b = p.fracNumerator[15:8];
      end
      `DRP_IDX_NUM_HIGH: begin
        b = p.fracNumerator[23:16];
      end
      `DRP_IDX_MOD_LOW: begin
        b = p.fracModulus[7:0];
      end
      `DRP_IDX_MOD_MID: begin
        b = p.fracModulus[15:8];
      end
      `DRP_IDX_MOD_HIGH: begin
        b = p.fracModulus[23:16];
      end
      default: begin
        b = 8'h00;
      end
    endcase
    return b;
  endfunction : readByte

  // Returns the profile with one byte written in
  function automatic drp_profile_type writeByte(
    input drp_profile_type p,
    input logic [7:0] low,
    input logic [7:0] d
  );
    drp_profile_type q;
    q = p;
    case ({4'h4, low})
      `DRP_IDX_PRIO_EN: begin
        q.priorityLevel = d[`DRP_PRIO_LSB +: 2]; // RULE1
        q.enable = d[`DRP_EN_BIT]; // RULE2
      end
      `DRP_IDX_BW_LOW: begin
        q.loopBandwidth[7:0] = d; // RULE3
      end
      `DRP_IDX_BW_MID: begin
        q.loopBandwidth[15:8] = d; // RULE3
      end
      `DRP_IDX_BW_TOP_FILT: begin
        q.loopBandwidth[16] = d[`DRP_BW_TOP_BIT]; // RULE3
        q.highMarginFilter = d[`DRP_FILT_BIT]; // RULE6
      end
      `DRP_IDX_INT_LOW: begin
        q.intDivMinusOne[7:0] = d; // RULE8
      end
      `DRP_IDX_INT_MID: begin
        q.intDivMinusOne[15:8] = d; // RULE8
      end
      `DRP_IDX_INT_TOP: begin
        q.intDivMinusOne[17:16] = d[1:0]; // RULE8
      end
      `DRP_IDX_NUM_LOW: begin
        q.fracNumerator[7:0] = d; // RULE9
      end
      `DRP_IDX_NUM_MID: begin
        q.fracNumerator[15:8] = d; // RULE9
      end
      `DRP_IDX_NUM_HIGH: begin
        q.fracNumerator[23:16] = d; // RULE9
      end
      `DRP_IDX_MOD_LOW: begin
        q.fracModulus[7:0] = d; // RULE10
      end
      `DRP_IDX_MOD_MID: begin
        q.fracModulus[15:8] = d; // RULE10
      end
      `DRP_IDX_MOD_HIGH: begin
        q.fracModulus[23:16] = d; // RULE10
      end
      default: begin
        q = p;
      end
    endcase
    return q;
  endfunction : writeByte

  // Reset contents of one profile
  function automatic drp_profile_type resetProfile();
    drp_profile_type r;
    r.priorityLevel = `DRP_RST_PRIO;
    r.enable = `DRP_RST_EN;
    r.loopBandwidth = `DRP_RST_BW;
    r.highMarginFilter = `DRP_RST_FILT;
    r.intDivMinusOne = `DRP_RST_INT;
    r.fracNumerator = `DRP_RST_FRAC;
    r.fracModulus = `DRP_RST_FRAC;
    return r;
  endfunction : resetProfile

  // Profiles of channels zero, one and two
  drp_profile_type profile [3];
  drp_profile_type next_profile [3];
  // Handshake state
  drp_bus_state_type busState;
  drp_bus_state_type next_busState;
  // Registered answer
  logic ack;
  logic next_ack;
  logic [31:0] readData;
  logic [31:0] next_readData;
  // Channel and group of the last answered access
  drp_decode_type lastAccess;
  drp_decode_type next_lastAccess;
  // Decode of the current request
  drp_decode_type req;

  // Current request decode
  assign req = decodeIndex(wb_adr_i[13:2]);

  // Next state of the bus slave and the register file
  always_comb begin
    next_profile = profile;
    next_busState = busState;
    next_ack = 1'b0;
    next_readData = 32'h00000000;
    next_lastAccess = lastAccess;
    case (busState)
      // Take a request and present its read data with ack
      BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          next_ack = 1'b1;
          next_busState = BUS_ANSWER;
          if (req.group == GRP_REF_FOURTH) begin
            next_readData = {24'h000000, readByte(profile[req.channel], req.low)}; // RULE14
          end else if (req.group == GRP_STATUS) begin
            next_readData = {19'h00000, lastAccess.channel, lastAccess.group, lastAccess.low};
          end else begin
            // Mirrored groups not held here and unmapped addresses read zero
            next_readData = 32'h00000000;
          end
        end
      end
      // Ack is high now; the write lands on this edge
      BUS_ANSWER: begin
        next_busState = BUS_IDLE;
        if (wb_cyc_i && wb_stb_i) begin
          next_lastAccess = req;
          if (wb_we_i && wb_sel_i[0] && req.group == GRP_REF_FOURTH) begin
            next_profile[req.channel] = writeByte(profile[req.channel], req.low, wb_dat_i[7:0]); // RULE14
          end
        end
      end
      default: begin
        next_busState = BUS_IDLE;
      end
    endcase
  end

  // Registers of the bus slave and the register file
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 3; i++) begin
        profile[i] <= resetProfile(); // RULE11
      end
      busState <= BUS_IDLE;
      ack <= 1'b0;
      readData <= 32'h00000000;
      lastAccess <= '{channel: 2'd0, group: GRP_NONE, low: 8'h00};
    end else begin
      profile <= next_profile;
      busState <= next_busState;
      ack <= next_ack;
      readData <= next_readData;
      lastAccess <= next_lastAccess;
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack_o = ack;
  assign wb_dat_o = readData;
  assign profileChannelZero = profile[0];
  assign profileChannelOne = profile[1]; // RULE12
  assign profileChannelTwo = profile[2]; // RULE15

endmodule : drp_reference_profile_regs

//--- verif/drp_profile_monitor.sv
/*
  Checker of the profile bank: bus answer timing and field updates.
  Assumes a bind from the bench top and one clock with async reset.
*/
`timescale 1ns/1ps
module drp_profile_monitor
  import drp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire drp_profile_type profileChannelZero,
  input wire drp_profile_type profileChannelOne,
  input wire drp_profile_type profileChannelTwo
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Write committing at this edge with lane zero on
  logic wrEdge;
  assign wrEdge = wb_ack_o && wb_we_i && wb_sel_i[0];
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
  req_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data off ack");
  reserved_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[13:2] == 12'h467 |->
    wb_dat_o[31:3] == 29'h0) else $error("reserved bits set");
  prio_en_a: assert property (wrEdge && wb_adr_i[13:2] == 12'h467 |=>
    {profileChannelZero.priorityLevel, profileChannelZero.enable} == $past(wb_dat_i[2:0])) else $error("prio");
  filt_bw_a: assert property (wrEdge && wb_adr_i[13:2] == 12'h46a |=>
    {profileChannelZero.highMarginFilter, profileChannelZero.loopBandwidth[16]} == $past(wb_dat_i[1:0]))
    else $error("filter");
  int_top_a: assert property (wrEdge && wb_adr_i[13:2] == 12'h46d |=>
    profileChannelZero.intDivMinusOne[17:16] == $past(wb_dat_i[1:0])) else $error("int top");
  ch_one_a: assert property (wrEdge && wb_adr_i[13:2] == 12'h567 |=>
    profileChannelOne.enable == $past(wb_dat_i[0])) else $error("channel one");
  ch_two_a: assert property (wrEdge && wb_adr_i[13:2] == 12'h673 |=>
    profileChannelTwo.fracModulus[23:16] == $past(wb_dat_i[7:0])) else $error("channel two");
endmodule : drp_profile_monitor

//--- verif/tb.sv
/*
  Self-checking bench of the profile bank over classic Wishbone.
  Assumes the package and the checker are compiled first.
*/
`timescale 1ns/1ps
module tb
  import drp_pkg::*;
;
  logic clk, reset, cyc, stb, wen, ack, s0;
  logic [13:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [15:0] seed;
  logic [7:0] mdl [3][13]; // Expected register bytes per channel
  drp_profile_type prof0, prof1, prof2;
  int failures, samplesChecked, c, r;
  drp_reference_profile_regs DUT (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wen),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .profileChannelZero(prof0), .profileChannelOne(prof1), .profileChannelTwo(prof2));
  // Bits held by each profile register
  function automatic logic [7:0] fmask(input int k);
    return (k == 0) ? 8'h07 : (k == 3 || k == 6) ? 8'h03 : 8'hff;
  endfunction : fmask
  // Profile fields assembled from the expected bytes
  function automatic drp_profile_type eprof(input int k);
    return {mdl[k][0][2:0], mdl[k][3][0], mdl[k][2], mdl[k][1], mdl[k][3][1], mdl[k][6][1:0], mdl[k][5],
      mdl[k][4], mdl[k][9], mdl[k][8], mdl[k][7], mdl[k][12], mdl[k][11], mdl[k][10]};
  endfunction : eprof
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    samplesChecked++;
    if (g !== e) begin
      failures++;
      $display("FAIL read expected %h seen %h", e, g);
    end
  endtask : chk
  task automatic chkp(input drp_profile_type e, input drp_profile_type g);
    samplesChecked++;
    if (g !== e) begin
      failures++;
      $display("FAIL profile expected %h seen %h", e, g);
    end
  endtask : chkp
  task automatic give_verdict();
    $display("checks %0d failures %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d, input logic s, output logic [31:0] v);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= w;
    adr <= {idx, 2'b00};
    sel <= {3'h0, s};
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    v = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      failures++;
      give_verdict();
    end
  endtask : wb
  // Read back every profile register and the three outputs
  task automatic chkall();
    for (int k = 0; k < 3; k++) begin
      for (int j = 0; j < 13; j++) begin
        wb(1'b0, 12'(12'h467 + 256 * k + j), 8'h00, 1'b1, q);
        chk({24'h0, mdl[k][j]}, q);
      end
    end
    chkp(eprof(0), prof0);
    chkp(eprof(1), prof1);
    chkp(eprof(2), prof2);
  endtask : chkall
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    {cyc, stb, wen, adr, sel, wdat} = '0;
    failures = 0;
    samplesChecked = 0;
    seed = 16'h0034;
    mdl = '{default: 8'h00};
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    chkall();
    // All ones everywhere shows the reserved bits
    for (c = 0; c < 3; c++) begin
      for (r = 0; r < 13; r++) begin
        wb(1'b1, 12'(12'h467 + 256 * c + r), 8'hff, 1'b1, q);
        mdl[c][r] = fmask(r);
      end
    end
    chkall();
    // Random traffic; a quarter of writes have lane zero off
    repeat (150) begin
      seed = lfsr(seed);
      c = int'(seed[1:0]) % 3;
      r = int'(seed[7:2]) % 13;
      seed = lfsr(seed);
      s0 = seed[9] | seed[8];
      wb(1'b1, 12'(12'h467 + 256 * c + r), seed[7:0], s0, q);
      if (s0) mdl[c][r] = seed[7:0] & fmask(r);
      // Status shows the access just acked, whatever its lane
      wb(1'b0, 12'h7f0, 8'h00, 1'b1, q);
      chk({19'h0, 2'(c), 3'd5, 8'(8'h67 + r)}, q);
    end
    // Legal loop settings: 1 kHz bandwidth, normal margin filter
    wb(1'b1, 12'h468, 8'h10, 1'b1, q);
    wb(1'b1, 12'h469, 8'h27, 1'b1, q);
    wb(1'b1, 12'h46a, 8'h00, 1'b1, q);
    mdl[0][1] = 8'h10;
    mdl[0][2] = 8'h27;
    mdl[0][3] = 8'h00;
    chkall();
    // Mirrored and unmapped places keep nothing here
    foreach (mdl[0][j]) begin
      wb(1'b1, 12'(12'h400 + 256 * (j % 4) + 16 * (j / 4)), 8'hff, 1'b1, q);
      wb(1'b0, 12'(12'h400 + 256 * (j % 4) + 16 * (j / 4)), 8'h00, 1'b1, q);
      chk(32'h0, q);
    end
    chkall();
    // Reset in mid-run clears every field
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    mdl = '{default: 8'h00};
    chkall();
    give_verdict();
  end
endmodule : tb
bind drp_reference_profile_regs drp_profile_monitor mon (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .profileChannelZero(profileChannelZero),
  .profileChannelOne(profileChannelOne), .profileChannelTwo(profileChannelTwo));
